// *** core/asr_pkg.sv ***
package asr_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;

	// ------------------------------------------------------------
	// timing (ps) and derived cycle counts at 25 MHz
	// ------------------------------------------------------------
	localparam int CLK_PS = 40000;
	// write strobe width with output enable low, slow grade (worst case)
	localparam int T_WE_PULSE_PS = 10000;
	// address and lane setup to write end, slow grade
	localparam int T_ADDR_SETUP_PS = 8000;
	// data setup to write end, slow grade
	localparam int T_DATA_SETUP_PS = 6000;
	// address access time, slow grade
	localparam int T_ACCESS_PS = 10000;
	// least write low time: round up, at least one cycle
	localparam int WR_CYC_RAW = (T_WE_PULSE_PS + CLK_PS - 1) / CLK_PS;
	localparam int WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
	// read wait: access time rounded up, plus one cycle for input sampling
	localparam int RD_CYC_RAW = (T_ACCESS_PS + CLK_PS - 1) / CLK_PS;
	localparam int RD_CYC = ((RD_CYC_RAW < 1) ? 1 : RD_CYC_RAW) + 1;
	localparam int CNT_W = 4;

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ASR_IDLE  = 5'b00001,
		ASR_WSET  = 5'b00010,
		ASR_WLOW  = 5'b00100,
		ASR_RWAIT = 5'b01000,
		ASR_DONE  = 5'b10000
	} asr_state_t;

endpackage

// *** core/asr_host.sv ***
`timescale 1ns/1ns
// Operation
// - all controls are valid before a write starts, and raising any one of them ends it.
// - write data is held stable for the setup before and hold after the write-ending edge.
// - the address is stable at least the address setup time before the write ends.
// - the address may change as soon as the write ends since its hold is zero.
// - the lane selects are valid at least the lane setup time before the write ends.
// - with output enable low the write strobe is held low at least the long pulse width.
// - the write strobe stays high throughout every read cycle.
// - for a read started by chip select the address is valid no later than chip select falling.
module asr_host (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [asr_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [asr_pkg::DATA_W-1:0] req_wdata_i,
	input wire logic [1:0] req_be_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [asr_pkg::DATA_W-1:0] rsp_rdata_o,
	output logic [asr_pkg::ADDR_W-1:0] mem_addr_o,
	output logic chip_select_n_o,
	output logic output_enable_n_o,
	output logic write_enable_n_o,
	output logic low_byte_select_n_o,
	output logic high_byte_select_n_o,
	input wire logic [asr_pkg::DATA_W-1:0] mem_data_i,
	output logic [asr_pkg::DATA_W-1:0] mem_data_o,
	output logic mem_data_oe_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	asr_pkg::asr_state_t state_q;
	asr_pkg::asr_state_t state_d;
	logic [asr_pkg::CNT_W-1:0] cnt_q;
	logic write_q;
	logic [1:0] be_q;
	logic take;
	logic cnt_zero;

	assign req_ready_o = (state_q == asr_pkg::ASR_IDLE);
	assign take = req_valid_i && req_ready_o;
	assign cnt_zero = (cnt_q == '0);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			asr_pkg::ASR_IDLE: begin
				if (take) begin
					state_d = req_write_i ? asr_pkg::ASR_WSET : asr_pkg::ASR_RWAIT;
				end
			end
			asr_pkg::ASR_WSET: begin
				state_d = asr_pkg::ASR_WLOW;
			end
			asr_pkg::ASR_WLOW: begin
				if (cnt_zero) begin
					state_d = asr_pkg::ASR_DONE;
				end
			end
			asr_pkg::ASR_RWAIT: begin
				if (cnt_zero) begin
					state_d = asr_pkg::ASR_DONE;
				end
			end
			asr_pkg::ASR_DONE: begin
				state_d = asr_pkg::ASR_IDLE;
			end
			default: begin
				state_d = asr_pkg::ASR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= asr_pkg::ASR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// cycle counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (take && !req_write_i) begin
			cnt_q <= asr_pkg::CNT_W'(asr_pkg::RD_CYC - 1);
		end else if (state_q == asr_pkg::ASR_WSET) begin
			cnt_q <= asr_pkg::CNT_W'(asr_pkg::WR_CYC - 1);
		end else if (!cnt_zero) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// address, data and lanes latched at acceptance
	// ------------------------------------------------------------
	// address, data and latched lanes change only in idle, so they stand a full
	// cycle before the strobe falls; address and data stand through its rising edge, the lane selects rise with it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_addr_o <= '0;
			mem_data_o <= '0;
			write_q <= 1'b0;
			be_q <= 2'b00;
		end else if (take) begin
			mem_addr_o <= req_addr_i;
			mem_data_o <= req_wdata_i;
			write_q <= req_write_i;
			be_q <= req_write_i ? req_be_i : 2'b11;
		end
	end

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// the memory is selected in every state of a transfer except its last
	function automatic logic is_busy(input asr_pkg::asr_state_t s);
		return (s == asr_pkg::ASR_WSET) || (s == asr_pkg::ASR_WLOW) || (s == asr_pkg::ASR_RWAIT);
	endfunction

	// at acceptance the request decides the lane, reads open both lanes,
	// later cycles keep what was latched
	function automatic logic lane_on(input logic taken, input logic wr, input logic req_bit,
		input logic held_bit);
		logic on;
		if (taken) begin
			on = !wr || req_bit;
		end else begin
			on = held_bit;
		end
		return on;
	endfunction

	logic busy_d;
	logic [1:0] lane_d;

	assign busy_d = is_busy(state_d);
	assign lane_d[0] = busy_d &&
		lane_on(take, req_write_i, req_be_i[0], be_q[0]);
	assign lane_d[1] = busy_d &&
		lane_on(take, req_write_i, req_be_i[1], be_q[1]);

	// ------------------------------------------------------------
	// pin strobes
	// ------------------------------------------------------------
	// write strobe low only in the timed write state; its rise ends the
	// write while address and data still stand
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			write_enable_n_o <= 1'b1;
		end else begin
			write_enable_n_o <= !(state_d == asr_pkg::ASR_WLOW);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			chip_select_n_o <= 1'b1;
		end else begin
			chip_select_n_o <= !busy_d;
		end
	end

	// output enable stays high through writes, so the memory never drives
	// against us while the strobe is low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			output_enable_n_o <= 1'b1;
		end else begin
			output_enable_n_o <= !(state_d == asr_pkg::ASR_RWAIT);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_byte_select_n_o <= 1'b1;
			high_byte_select_n_o <= 1'b1;
		end else begin
			low_byte_select_n_o <= !lane_d[0];
			high_byte_select_n_o <= !lane_d[1];
		end
	end

	// bus driven through the strobe's rise and released a cycle after,
	// so the memory output turn-on can never meet our drive
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_data_oe_o <= 1'b0;
		end else begin
			mem_data_oe_o <= (state_d == asr_pkg::ASR_WSET || state_d == asr_pkg::ASR_WLOW ||
				(state_d == asr_pkg::ASR_DONE && write_q));
		end
	end

	// ------------------------------------------------------------
	// read data and completion
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rsp_valid_o <= 1'b0;
		end else begin
			rsp_valid_o <= (state_d == asr_pkg::ASR_DONE);
		end
	end

	// sampled a full cycle after the access time has run out; stands until
	// the next read ends
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rsp_rdata_o <= '0;
		end else if (state_q == asr_pkg::ASR_RWAIT && cnt_zero) begin
			rsp_rdata_o <= mem_data_i;
		end
	end

endmodule // asr_host

// *** test/asr_sram_model.sv ***
`timescale 1ns/1ns
module asr_sram_model (
	input wire logic [asr_pkg::ADDR_W-1:0] addr_i,
	input wire logic cs_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic low_byte_select_n_i,
	input wire logic high_byte_select_n_i,
	input wire logic [asr_pkg::DATA_W-1:0] d_i,
	output logic [asr_pkg::DATA_W-1:0] q_o
);
	logic [15:0] mem [256];
	logic [15:0] rd;
	logic [15:0] last = 16'h0000;
	// only 256 words kept, tests use addresses whose low eight bits are distinct
	always @* begin
		if (!cs_n_i && !we_n_i && !low_byte_select_n_i) begin
			mem[addr_i[7:0]][7:0] = d_i[7:0];
		end
		if (!cs_n_i && !we_n_i && !high_byte_select_n_i) begin
			mem[addr_i[7:0]][15:8] = d_i[15:8];
		end
	end
	// a floating lane toggles so a stale value can never be mistaken for data
	always @* begin
		rd = mem[addr_i[7:0]];
		if (cs_n_i || oe_n_i || !we_n_i || low_byte_select_n_i) begin
			rd[7:0] = ~last[7:0];
		end
		if (cs_n_i || oe_n_i || !we_n_i || high_byte_select_n_i) begin
			rd[15:8] = ~last[15:8];
		end
	end
	assign #8 q_o = rd;
	always @(q_o) last = q_o;
endmodule // asr_sram_model

// *** test/asr_host_props.sv ***
`timescale 1ns/1ns
module asr_host_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [asr_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	input wire logic [asr_pkg::ADDR_W-1:0] mem_addr_o,
	input wire logic chip_select_n_o,
	input wire logic output_enable_n_o,
	input wire logic write_enable_n_o,
	input wire logic low_byte_select_n_o,
	input wire logic high_byte_select_n_o,
	input wire logic [asr_pkg::DATA_W-1:0] mem_data_o,
	input wire logic mem_data_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = req_valid_i && req_ready_o;
	wire we_n = write_enable_n_o;
	wire [1:0] ln = {high_byte_select_n_o, low_byte_select_n_o};
	chk_read_strobe: assert property (
		!output_enable_n_o |-> we_n) else $error("strobe low in read");
	chk_write_ctl: assert property (
		!we_n |-> !chip_select_n_o && ln != 2'h3 && mem_data_oe_o) else $error("bad write");
	chk_addr_setup: assert property (
		!we_n |-> $stable(mem_addr_o)) else $error("address moved");
	chk_lane_setup: assert property (
		!we_n |-> $stable(ln)) else $error("lanes moved");
	chk_data_hold: assert property (
		$rose(we_n) |-> mem_data_oe_o && $stable(mem_data_o)) else $error("data hold");
	chk_pulse_end: assert property (
		$fell(we_n) |=> we_n && chip_select_n_o) else $error("pulse width");
	chk_addr_first: assert property (
		take |=> !chip_select_n_o && mem_addr_o == $past(req_addr_i)) else $error("addr");
	chk_write_walk: assert property (
		take && req_write_i |=> we_n ##1 !we_n ##1 we_n && rsp_valid_o ##1 req_ready_o)
		else $error("walk");
	cov_write: cover property (take && req_write_i);
	cov_read: cover property (take && !req_write_i);
	cov_done: cover property (rsp_valid_o);
endmodule // asr_host_props

// *** test/asr_host_tb_top.sv ***
`timescale 1ns/1ns
module asr_host_tb_top;
	logic clk_i = 1'h0, rst_i = 1'h1, req_valid_i = 1'h0, req_write_i = 1'h0;
	logic [17:0] req_addr_i = 18'h0, mem_addr_o;
	logic [15:0] req_wdata_i = 16'h0, rsp_rdata_o, mem_data_o, mem_data_i, sram_q;
	logic [1:0] req_be_i = 2'h0;
	logic req_ready_o, rsp_valid_o, chip_select_n_o, output_enable_n_o, write_enable_n_o;
	logic low_byte_select_n_o, high_byte_select_n_o, mem_data_oe_o;
	int num_errors = 0, comparisons = 0;
	assign mem_data_i = mem_data_oe_o ? mem_data_o : sram_q;
	asr_host dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
		.req_be_i(req_be_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
		.rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr_o), .chip_select_n_o(chip_select_n_o),
		.output_enable_n_o(output_enable_n_o), .write_enable_n_o(write_enable_n_o),
		.low_byte_select_n_o(low_byte_select_n_o), .high_byte_select_n_o(high_byte_select_n_o),
		.mem_data_i(mem_data_i), .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));
	asr_sram_model u_sram (.addr_i(mem_addr_o), .cs_n_i(chip_select_n_o),
		.oe_n_i(output_enable_n_o), .we_n_i(write_enable_n_o),
		.low_byte_select_n_i(low_byte_select_n_o),
		.high_byte_select_n_i(high_byte_select_n_o), .d_i(mem_data_i), .q_o(sram_q));
	always #20 clk_i = ~clk_i;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic wr, input logic [17:0] a, input logic [15:0] d,
		input logic [1:0] be);
		@(posedge clk_i);
		req_valid_i <= 1'h1;
		req_write_i <= wr;
		req_addr_i <= a;
		req_wdata_i <= d;
		req_be_i <= be;
		do @(posedge clk_i); while (!req_ready_o);
		req_valid_i <= 1'h0;
		for (int i = 0; i < 8 && rsp_valid_o !== 1'h1; i++) @(negedge clk_i);
		check({15'h0, rsp_valid_o}, 16'h1);
	endtask
	task automatic rd(input logic [17:0] a, input logic [15:0] exp);
		xfer(1'h0, a, 16'h0, 2'h3);
		check(rsp_rdata_o, exp);
	endtask
	task automatic t_lanes;
		xfer(1'h1, 18'h9, 16'h1234, 2'h3);
		xfer(1'h1, 18'h9, 16'hAB56, 2'h1);
		rd(18'h9, 16'h1256);
		xfer(1'h1, 18'h9, 16'h99EE, 2'h2);
		rd(18'h9, 16'h9956);
	endtask
	task automatic t_edges;
		xfer(1'h1, 18'h3FFFF, 16'hA5C3, 2'h3);
		xfer(1'h1, 18'h1, 16'h5A3C, 2'h3);
		rd(18'h3FFFF, 16'hA5C3);
		rd(18'h1, 16'h5A3C);
	endtask
	initial begin
		@(negedge clk_i);
		check({11'h0, chip_select_n_o, output_enable_n_o, write_enable_n_o,
			low_byte_select_n_o, high_byte_select_n_o}, 16'h1F);
		@(posedge clk_i);
		rst_i <= 1'h0;
		t_lanes;
		t_edges;
		finish_test;
	end
	initial begin
		#20000;
		num_errors++;
		finish_test;
	end
endmodule // asr_host_tb_top
bind asr_host asr_host_props u_props (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
	.req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_ready_o(req_ready_o),
	.rsp_valid_o(rsp_valid_o), .mem_addr_o(mem_addr_o), .chip_select_n_o(chip_select_n_o),
	.output_enable_n_o(output_enable_n_o), .write_enable_n_o(write_enable_n_o),
	.low_byte_select_n_o(low_byte_select_n_o), .high_byte_select_n_o(high_byte_select_n_o),
	.mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));
